/* shared/emcr_map.svh */
// Register indices, field positions and reset values of the memory config bank
`ifndef EMCR_MAP_SVH
`define EMCR_MAP_SVH

// Register indices; byte address on the bus is index times four
`define EMCR_IDX_PAR_DATA  10'h230
`define EMCR_IDX_PAR_HI    10'h232
`define EMCR_IDX_PAR_LO    10'h234
`define EMCR_IDX_GEOM      10'h240
`define EMCR_IDX_RXBASE    10'h242
`define EMCR_IDX_SDCTL     10'h250
`define EMCR_IDX_REFIVL    10'h252
`define EMCR_IDX_IDLE_ADDR 10'h256
`define EMCR_IDX_MAN_ADDR  10'h258
`define EMCR_IDX_PIN_CMD   10'h25A

// Writable bits per register; everything else reads as zero
`define EMCR_MSK_PAR_DATA  16'hFF00
`define EMCR_MSK_PAR_HI    16'h007F
`define EMCR_MSK_PAR_LO    16'hFFFF
`define EMCR_MSK_GEOM      16'h01FF
`define EMCR_MSK_RXBASE    16'h00FF
`define EMCR_MSK_SDCTL     16'h00F3
`define EMCR_MSK_REFIVL    16'hFFFF
`define EMCR_MSK_PIN_ADDR  16'h3FFF
`define EMCR_MSK_PIN_CMD   16'h003F

// Reset values
`define EMCR_RST_ZERO      16'h0000
`define EMCR_RST_GEOM      16'h0075
`define EMCR_RST_REFIVL    16'h0400
`define EMCR_RST_PIN_CMD   16'h003F

// Field positions
`define EMCR_GEOM_DEPTH_A  0
`define EMCR_GEOM_DEPTH_B  2
`define EMCR_GEOM_CAP      4
`define EMCR_GEOM_RING     6
`define EMCR_GEOM_BPRES    8
`define EMCR_SD_EN_A       0
`define EMCR_SD_EN_B       1
`define EMCR_SD_MAN_A      2
`define EMCR_SD_MAN_B      3
`define EMCR_SD_SIZE_A     4
`define EMCR_SD_SIZE_B     5
`define EMCR_SD_RATE       6
`define EMCR_CMD_MAN       3
`define EMCR_RXBASE_SHIFT  13

`endif

/* shared/emcr_pkg.sv */
// Types shared by the memory config bank and its SDRAM pin drivers
package emcr_pkg;
  typedef logic [15:0] emcr_word_t;
  typedef logic [13:0] emcr_pin_addr_t;
  // Command lines, bit 0 cas, bit 1 ras, bit 2 we
  typedef logic [2:0]  emcr_pin_cmd_t;
  typedef enum logic [2:0] {
    DRV_IDLE = 3'b001,
    DRV_MAN  = 3'b010,
    DRV_RUN  = 3'b100
  } emcr_drv_state_t;
endpackage

/* shared/emcr_bank_if.sv */
// Control and pin values passed between the register bank and one SDRAM bank driver
interface emcr_bank_if;
  import emcr_pkg::*;
  logic           enable;
  logic           man_go;
  emcr_pin_addr_t idle_addr;
  emcr_pin_cmd_t  idle_cmd;
  emcr_pin_addr_t man_addr;
  emcr_pin_cmd_t  man_cmd;
  emcr_pin_addr_t acc_addr;
  emcr_pin_cmd_t  acc_cmd;
  emcr_pin_addr_t pin_addr;
  emcr_pin_cmd_t  pin_cmd;
  modport ctrl (output enable, man_go, idle_addr, idle_cmd, man_addr, man_cmd,
                acc_addr, acc_cmd, input pin_addr, pin_cmd);
  modport drv  (input enable, man_go, idle_addr, idle_cmd, man_addr, man_cmd,
                acc_addr, acc_cmd, output pin_addr, pin_cmd);
endinterface

/* logic/emcr_bank_drv.sv */
// Pin driver for one SDRAM bank: idle, one-cycle manual, or normal traffic
module emcr_bank_drv
  import emcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  emcr_bank_if.drv bk
);

  emcr_drv_state_t state_ff;
  emcr_drv_state_t nxt_state;
  emcr_pin_addr_t  pin_addr_ff;
  emcr_pin_cmd_t   pin_cmd_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DRV_IDLE: begin
        if (bk.enable) nxt_state = DRV_RUN;
        else if (bk.man_go) nxt_state = DRV_MAN;
      end
      DRV_MAN: begin
        nxt_state = bk.enable ? DRV_RUN : DRV_IDLE;
      end
      DRV_RUN: begin
        if (!bk.enable) nxt_state = bk.man_go ? DRV_MAN : DRV_IDLE;
      end
      default: nxt_state = DRV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state_ff <= DRV_IDLE;
    else state_ff <= nxt_state;
  end

  // pins follow the state being entered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_addr_ff <= '0;
      pin_cmd_ff  <= 3'h7;
    end else begin
      case (nxt_state)
        DRV_MAN: begin
          pin_addr_ff <= bk.man_addr;
          pin_cmd_ff  <= bk.man_cmd;
        end
        DRV_RUN: begin
          pin_addr_ff <= bk.acc_addr;
          pin_cmd_ff  <= bk.acc_cmd;
        end
        default: begin
          pin_addr_ff <= bk.idle_addr;
          pin_cmd_ff  <= bk.idle_cmd;
        end
      endcase
    end
  end

  assign bk.pin_addr = pin_addr_ff;
  assign bk.pin_cmd  = pin_cmd_ff;

  // Checks the pins, not the state, so a stuck manual value is caught
  a_manual_one_cycle: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_ff == DRV_MAN && !bk.enable) |=>
      (pin_addr_ff == $past(bk.idle_addr)) && (pin_cmd_ff == $past(bk.idle_cmd)))
    else $error("manual values held longer than one cycle");

  a_manual_values: assert property (
    @(posedge clk) disable iff (!reset_n)
    (bk.man_go && !bk.enable) |=>
      (pin_addr_ff == $past(bk.man_addr)) && (pin_cmd_ff == $past(bk.man_cmd)))
    else $error("manual pin values not driven after manual access");

  a_idle_values: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!bk.enable && !bk.man_go) |=>
      (pin_addr_ff == $past(bk.idle_addr)) && (pin_cmd_ff == $past(bk.idle_cmd)))
    else $error("idle pin values not held while bank disabled");

  a_run_traffic: assert property (
    @(posedge clk) disable iff (!reset_n)
    bk.enable |=> pin_addr_ff == $past(bk.acc_addr))
    else $error("enabled bank does not carry access traffic");

endmodule

/* logic/emcr_regs.sv */
// External memory configuration register bank with Wishbone slave
// Notes on behaviour
// - Address bit joins parity when its bit in the 23-bit select mask is one.
// - Two-bit chip depth per bank selects 128, 256, 512 or 1024 Kb per chip.
// - Capacity field selects 128, 256, 512 or 1023 channels.
// - Ring size field gives 256, 512 or 1024 byte receive rings; 00 reserved.
// - Bit 8 of geometry register says whether bank B is fitted.
// - Receive base is field times 8 KB in bank A, ignored when bank B fitted.
// - Disabled SDRAM bank pins carry the programmed idle values.
// - Writing manual bit on disabled bank drives the manual values; bit self-clears.
// - Size bit per SDRAM bank: zero 8 MB, one 16 MB.
// - Refresh rate field: one refresh per 16, 8 or 4 cycles; 00 typical.
// - Refreshes are spaced by the 16-bit interval count, reset 0400h.
// - Disabled bank address lines hold the 14-bit idle address.
// - Manual values last exactly one cycle, then idle values return, or traffic if that same write set the bank's enable bit.
`include "emcr_map.svh"

module emcr_regs
  import emcr_pkg::*;
#(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 8
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output      logic [31:0] WB_DAT_O,
  output      logic        WB_ACK_O,
  input  wire logic [22:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_DATA,
  output      logic        MEM_PARITY,
  output      logic [10:0] BANK_A_CHIP_KB,
  output      logic [10:0] BANK_B_CHIP_KB,
  output      logic [9:0]  CHANNEL_COUNT,
  output      logic [10:0] RX_RING_BYTES,
  output      logic        BANK_B_PRESENT,
  output      logic [20:0] RX_BASE_ADDR,
  output      logic        SDA_IS_16MB,
  output      logic        SDB_IS_16MB,
  output      logic [4:0]  REFRESH_SPACING,
  output      logic        REFRESH_REQ,
  input  wire logic [13:0] ACC_ADDR,
  input  wire logic [2:0]  ACC_CMD,
  output      logic [13:0] SDA_ADDR,
  output      logic [2:0]  SDA_CMD,
  output      logic [13:0] SDB_ADDR,
  output      logic [2:0]  SDB_CMD
);

  // Mask widths are fixed by the register layout
  if (ADDR_W != 23 || DATA_W != 8) begin : g_width_check
    $error("emcr_regs supports only ADDR_W 23 and DATA_W 8");
  end

  function automatic emcr_word_t wmerge(emcr_word_t old, emcr_word_t d,
                                        logic [1:0] sel, emcr_word_t msk);
    emcr_word_t be;
    be = {{8{sel[1]}}, {8{sel[0]}}} & msk;
    return (old & ~be) | (d & be);
  endfunction

  function automatic logic [10:0] chip_kb(logic [1:0] d);
    return 11'(11'h080 << d);
  endfunction

  function automatic logic [9:0] chan_cnt(logic [1:0] c);
    logic [9:0] n;
    case (c)
      2'h0:    n = 10'h080;
      2'h1:    n = 10'h100;
      2'h2:    n = 10'h200;
      default: n = 10'h3FF;
    endcase
    return n;
  endfunction

  // Reserved ring code reports zero so a consumer can spot the misprogramming
  function automatic logic [10:0] ring_bytes(logic [1:0] r);
    return (r == 2'h0) ? 11'h000 : 11'(11'h080 << r);
  endfunction

  function automatic logic [4:0] rf_spacing(logic [1:0] r);
    logic [4:0] s;
    case (r)
      2'h1:    s = 5'h08;
      2'h2:    s = 5'h04;
      default: s = 5'h10;
    endcase
    return s;
  endfunction

  localparam emcr_word_t RST_GEOM = `EMCR_RST_GEOM;

  emcr_word_t  par_data_ff;
  emcr_word_t  par_hi_ff;
  emcr_word_t  par_lo_ff;
  emcr_word_t  geom_ff;
  emcr_word_t  rxbase_ff;
  emcr_word_t  sdctl_ff;
  emcr_word_t  refivl_ff;
  emcr_word_t  idle_addr_ff;
  emcr_word_t  man_addr_ff;
  emcr_word_t  pin_cmd_ff;
  emcr_word_t  rd_word;
  logic        ack_ff;
  logic [31:0] rd_data_ff;
  logic        bus_req;
  logic        wr_go;
  logic [9:0]  widx;
  emcr_word_t  wdat;
  logic [1:0]  wsel;
  logic        man_a_go;
  logic        man_b_go;
  logic        parity_ff;
  logic [15:0] ref_cnt_ff;
  logic        ref_req_ff;
  logic        ref_run;
  logic        ivl_wr;

  assign bus_req = WB_CYC_I & WB_STB_I;
  assign widx    = WB_ADR_I[11:2];
  assign wdat    = WB_DAT_I[15:0];
  assign wsel    = WB_SEL_I[1:0];
  // Writes land on the edge where the master samples the acknowledge
  assign wr_go   = bus_req & WB_WE_I & ack_ff;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) ack_ff <= 1'b0;
    else ack_ff <= bus_req & ~ack_ff;
  end

  always_comb begin
    rd_word = 16'h0000;
    if (widx == `EMCR_IDX_PAR_DATA) rd_word = par_data_ff;
    else if (widx == `EMCR_IDX_PAR_HI) rd_word = par_hi_ff;
    else if (widx == `EMCR_IDX_PAR_LO) rd_word = par_lo_ff;
    else if (widx == `EMCR_IDX_GEOM) rd_word = geom_ff;
    else if (widx == `EMCR_IDX_RXBASE) rd_word = rxbase_ff;
    else if (widx == `EMCR_IDX_SDCTL) rd_word = sdctl_ff;
    else if (widx == `EMCR_IDX_REFIVL) rd_word = refivl_ff;
    else if (widx == `EMCR_IDX_IDLE_ADDR) rd_word = idle_addr_ff;
    else if (widx == `EMCR_IDX_MAN_ADDR) rd_word = man_addr_ff;
    else if (widx == `EMCR_IDX_PIN_CMD) rd_word = pin_cmd_ff;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) rd_data_ff <= 32'h0000_0000;
    else if (bus_req & ~ack_ff & ~WB_WE_I) rd_data_ff <= {16'h0000, rd_word};
  end

  // Reserved bits are never stored, so a careless write cannot steer the block
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      par_data_ff  <= `EMCR_RST_ZERO;
      par_hi_ff    <= `EMCR_RST_ZERO;
      par_lo_ff    <= `EMCR_RST_ZERO;
      geom_ff      <= `EMCR_RST_GEOM;
      rxbase_ff    <= `EMCR_RST_ZERO;
      sdctl_ff     <= `EMCR_RST_ZERO;
      refivl_ff    <= `EMCR_RST_REFIVL;
      idle_addr_ff <= `EMCR_RST_ZERO;
      man_addr_ff  <= `EMCR_RST_ZERO;
      pin_cmd_ff   <= `EMCR_RST_PIN_CMD;
    end else if (wr_go) begin
      if (widx == `EMCR_IDX_PAR_DATA)
        par_data_ff <= wmerge(par_data_ff, wdat, wsel, `EMCR_MSK_PAR_DATA);
      else if (widx == `EMCR_IDX_PAR_HI)
        par_hi_ff <= wmerge(par_hi_ff, wdat, wsel, `EMCR_MSK_PAR_HI);
      else if (widx == `EMCR_IDX_PAR_LO)
        par_lo_ff <= wmerge(par_lo_ff, wdat, wsel, `EMCR_MSK_PAR_LO);
      else if (widx == `EMCR_IDX_GEOM)
        geom_ff <= wmerge(geom_ff, wdat, wsel, `EMCR_MSK_GEOM);
      else if (widx == `EMCR_IDX_RXBASE)
        rxbase_ff <= wmerge(rxbase_ff, wdat, wsel, `EMCR_MSK_RXBASE);
      else if (widx == `EMCR_IDX_SDCTL)
        sdctl_ff <= wmerge(sdctl_ff, wdat, wsel, `EMCR_MSK_SDCTL);
      else if (widx == `EMCR_IDX_REFIVL)
        refivl_ff <= wmerge(refivl_ff, wdat, wsel, `EMCR_MSK_REFIVL);
      else if (widx == `EMCR_IDX_IDLE_ADDR)
        idle_addr_ff <= wmerge(idle_addr_ff, wdat, wsel, `EMCR_MSK_PIN_ADDR);
      else if (widx == `EMCR_IDX_MAN_ADDR)
        man_addr_ff <= wmerge(man_addr_ff, wdat, wsel, `EMCR_MSK_PIN_ADDR);
      else if (widx == `EMCR_IDX_PIN_CMD)
        pin_cmd_ff <= wmerge(pin_cmd_ff, wdat, wsel, `EMCR_MSK_PIN_CMD);
    end
  end

  assign man_a_go = wr_go & (widx == `EMCR_IDX_SDCTL) & wsel[0] & wdat[`EMCR_SD_MAN_A];
  assign man_b_go = wr_go & (widx == `EMCR_IDX_SDCTL) & wsel[0] & wdat[`EMCR_SD_MAN_B];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) parity_ff <= 1'b0;
    else parity_ff <= ^({MEM_ADDR & {par_hi_ff[6:0], par_lo_ff},
                         MEM_DATA & par_data_ff[15:8]});
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BANK_A_CHIP_KB <= chip_kb(RST_GEOM[1:0]);
      BANK_B_CHIP_KB <= chip_kb(RST_GEOM[3:2]);
      CHANNEL_COUNT  <= chan_cnt(RST_GEOM[5:4]);
      RX_RING_BYTES  <= ring_bytes(RST_GEOM[7:6]);
      BANK_B_PRESENT <= RST_GEOM[8];
    end else begin
      BANK_A_CHIP_KB <= chip_kb(geom_ff[`EMCR_GEOM_DEPTH_A +: 2]);
      BANK_B_CHIP_KB <= chip_kb(geom_ff[`EMCR_GEOM_DEPTH_B +: 2]);
      CHANNEL_COUNT  <= chan_cnt(geom_ff[`EMCR_GEOM_CAP +: 2]);
      RX_RING_BYTES  <= ring_bytes(geom_ff[`EMCR_GEOM_RING +: 2]);
      BANK_B_PRESENT <= geom_ff[`EMCR_GEOM_BPRES];
    end
  end

  // receive base in bank A only
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) RX_BASE_ADDR <= 21'h000000;
    else if (geom_ff[`EMCR_GEOM_BPRES]) RX_BASE_ADDR <= 21'h000000;
    else RX_BASE_ADDR <= {rxbase_ff[7:0], `EMCR_RXBASE_SHIFT'h0};
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SDA_IS_16MB     <= 1'b0;
      SDB_IS_16MB     <= 1'b0;
      REFRESH_SPACING <= 5'h10;
    end else begin
      SDA_IS_16MB     <= sdctl_ff[`EMCR_SD_SIZE_A];
      SDB_IS_16MB     <= sdctl_ff[`EMCR_SD_SIZE_B];
      REFRESH_SPACING <= rf_spacing(sdctl_ff[`EMCR_SD_RATE +: 2]);
    end
  end

  // Refresh ticks only while some bank is live; a new interval restarts the count
  assign ref_run = sdctl_ff[`EMCR_SD_EN_A] | sdctl_ff[`EMCR_SD_EN_B];
  assign ivl_wr  = wr_go & (widx == `EMCR_IDX_REFIVL);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ref_cnt_ff <= 16'h0000;
      ref_req_ff <= 1'b0;
    end else if (!ref_run || ivl_wr) begin
      ref_cnt_ff <= 16'h0000;
      ref_req_ff <= 1'b0;
    end else if (refivl_ff <= 16'h0001 || ref_cnt_ff >= refivl_ff - 16'h0001) begin
      ref_cnt_ff <= 16'h0000;
      ref_req_ff <= 1'b1;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 16'h0001;
      ref_req_ff <= 1'b0;
    end
  end

  emcr_bank_if bank_a ();
  emcr_bank_if bank_b ();

  // idle and manual values to both banks
  assign bank_a.enable    = sdctl_ff[`EMCR_SD_EN_A];
  assign bank_a.man_go    = man_a_go;
  assign bank_a.idle_addr = idle_addr_ff[13:0];
  assign bank_a.idle_cmd  = pin_cmd_ff[2:0];
  assign bank_a.man_addr  = man_addr_ff[13:0];
  assign bank_a.man_cmd   = pin_cmd_ff[`EMCR_CMD_MAN +: 3];
  assign bank_a.acc_addr  = ACC_ADDR;
  assign bank_a.acc_cmd   = ACC_CMD;
  assign bank_b.enable    = sdctl_ff[`EMCR_SD_EN_B];
  assign bank_b.man_go    = man_b_go;
  assign bank_b.idle_addr = idle_addr_ff[13:0];
  assign bank_b.idle_cmd  = pin_cmd_ff[2:0];
  assign bank_b.man_addr  = man_addr_ff[13:0];
  assign bank_b.man_cmd   = pin_cmd_ff[`EMCR_CMD_MAN +: 3];
  assign bank_b.acc_addr  = ACC_ADDR;
  assign bank_b.acc_cmd   = ACC_CMD;

  emcr_bank_drv u_drv_a (
    .clk     (CLK),
    .reset_n (RESET_N),
    .bk      (bank_a)
  );

  emcr_bank_drv u_drv_b (
    .clk     (CLK),
    .reset_n (RESET_N),
    .bk      (bank_b)
  );

  assign WB_ACK_O    = ack_ff;
  assign WB_DAT_O    = rd_data_ff;
  assign MEM_PARITY  = parity_ff;
  assign REFRESH_REQ = ref_req_ff;
  assign SDA_ADDR    = bank_a.pin_addr;
  assign SDA_CMD     = bank_a.pin_cmd;
  assign SDB_ADDR    = bank_b.pin_addr;
  assign SDB_CMD     = bank_b.pin_cmd;

  // Checking helpers: cycles since last refresh request
  logic [15:0] gap_ff;
  logic        armed_ff;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gap_ff   <= 16'h0000;
      armed_ff <= 1'b0;
    end else if (!ref_run || ivl_wr) begin
      gap_ff   <= 16'h0000;
      armed_ff <= 1'b0;
    end else if (ref_req_ff) begin
      gap_ff   <= 16'h0000;
      armed_ff <= 1'b1;
    end else begin
      gap_ff   <= gap_ff + 16'h0001;
    end
  end

  a_ack_single: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge lasted more than one cycle");

  a_refresh_gap: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    (REFRESH_REQ && armed_ff && refivl_ff > 16'h0001) |->
      gap_ff == refivl_ff - 16'h0001)
    else $error("refresh spacing differs from interval count");

  a_base_ignored: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    BANK_B_PRESENT |-> RX_BASE_ADDR == 21'h000000)
    else $error("receive base used while bank B present");

  a_base_scale: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    !$past(geom_ff[8]) |-> RX_BASE_ADDR == {$past(rxbase_ff[7:0]), 13'h0000})
    else $error("receive base not scaled by 8 KB");

  a_depth_max: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    $past(geom_ff[1:0]) == 2'h3 |-> BANK_A_CHIP_KB == 11'h400)
    else $error("depth 11 does not give 1 Mb per chip");

  a_chan_max: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    $past(geom_ff[5:4]) == 2'h3 |-> CHANNEL_COUNT == 10'h3FF)
    else $error("capacity 11 does not give 1023 channels");

  a_ring_size: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    $past(geom_ff[7:6]) == 2'h3 |-> RX_RING_BYTES == 11'h400)
    else $error("ring code 11 does not give 1024 bytes");

  a_spacing_typ: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    $past(sdctl_ff[7:6]) == 2'h0 |-> REFRESH_SPACING == 5'h10)
    else $error("rate 00 does not give one refresh per 16 cycles");

  a_parity_bit0: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    ($past(par_lo_ff) == 16'h0001 && $past(par_hi_ff) == 16'h0000 &&
     $past(par_data_ff) == 16'h0000) |-> MEM_PARITY == $past(MEM_ADDR[0]))
    else $error("parity does not follow the one selected address bit");

endmodule

/* verification/emcr_sdram_model.sv */
// Far-side SDRAM bank model: counts commands other than a no-operation
module emcr_sdram_model
  import emcr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire emcr_pin_addr_t addr,
  input  wire emcr_pin_cmd_t  cmd,
  output int                  cmd_cnt,
  output emcr_pin_addr_t      cmd_addr,
  output emcr_pin_cmd_t       cmd_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle versus command
  // All-high lines are a no-operation; an unknown level is taken as a command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_cnt  <= 0;
      cmd_addr <= '0;
      cmd_seen <= 3'h7;
    end else if (cmd !== 3'h7) begin
      cmd_cnt  <= cmd_cnt + 1;
      cmd_addr <= addr;
      cmd_seen <= cmd;
    end
  end
endmodule

/* verification/emcr_regs_tb.sv */
// Self-checking bench for the memory configuration register bank
`include "emcr_map.svh"

module emcr_regs_tb
  import emcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           cyc = 1'b0;
  logic           stb = 1'b0;
  logic           we = 1'b0;
  logic [11:0]    adr = '0;
  logic [3:0]     sel = 4'h3;
  logic [31:0]    wdat = '0;
  logic [31:0]    rdat;
  logic           ack;
  logic [22:0]    mem_addr = '0;
  logic [7:0]     mem_data = '0;
  logic           parity, bpres, sza, szb, rreq;
  logic [10:0]    a_kb, b_kb, ring;
  logic [9:0]     chans;
  logic [20:0]    rxbase;
  logic [4:0]     spacing;
  emcr_pin_addr_t acc_addr = '0;
  emcr_pin_cmd_t  acc_cmd = 3'h7;
  emcr_pin_addr_t sda_addr, sdb_addr, man_a, man_b;
  emcr_pin_cmd_t  sda_cmd, sdb_cmd, mcmd_a, mcmd_b;
  int             cnt_a, cnt_b, na, nb, n;
  int             mismatches = 0;
  int             num_checks = 0;
  emcr_word_t     g, q;
  logic [9:0]     ridx[9] = '{`EMCR_IDX_PAR_HI, `EMCR_IDX_PAR_LO, `EMCR_IDX_GEOM,
                              `EMCR_IDX_RXBASE, `EMCR_IDX_SDCTL, `EMCR_IDX_REFIVL,
                              `EMCR_IDX_IDLE_ADDR, `EMCR_IDX_PIN_CMD, 10'h3FF};
  emcr_word_t     rval[9] = '{16'h0000, 16'h0000, 16'h0075, 16'h0000, 16'h0000,
                              16'h0400, 16'h0000, 16'h003F, 16'h0000};
  logic [22:0]    pa[4] = '{23'h7FFFFF, 23'h550000, 23'h001234, 23'h2AEDCB};
  logic [7:0]     pd[4] = '{8'hFF, 8'h01, 8'h40, 8'h80};

  always #2 clk = ~clk;

  emcr_regs dut_u (
    .CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .MEM_PARITY(parity),
    .BANK_A_CHIP_KB(a_kb), .BANK_B_CHIP_KB(b_kb), .CHANNEL_COUNT(chans),
    .RX_RING_BYTES(ring), .BANK_B_PRESENT(bpres), .RX_BASE_ADDR(rxbase),
    .SDA_IS_16MB(sza), .SDB_IS_16MB(szb), .REFRESH_SPACING(spacing),
    .REFRESH_REQ(rreq), .ACC_ADDR(acc_addr), .ACC_CMD(acc_cmd),
    .SDA_ADDR(sda_addr), .SDA_CMD(sda_cmd), .SDB_ADDR(sdb_addr), .SDB_CMD(sdb_cmd)
  );

  emcr_sdram_model mdl_a (.clk(clk), .reset_n(rst_n), .addr(sda_addr), .cmd(sda_cmd),
                          .cmd_cnt(cnt_a), .cmd_addr(man_a), .cmd_seen(mcmd_a));
  emcr_sdram_model mdl_b (.clk(clk), .reset_n(rst_n), .addr(sdb_addr), .cmd(sdb_cmd),
                          .cmd_cnt(cnt_b), .cmd_addr(man_b), .cmd_seen(mcmd_b));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic bus(input logic [9:0] idx, input logic wr_en, input emcr_word_t d);
    int k;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr_en;
    adr  <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("bus ack", 1, 0);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input emcr_word_t d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [9:0] idx, input emcr_word_t exp);
    bus(idx, 1'b0, 16'h0000);
    chk($sformatf("reg %h", idx), exp, q);
  endtask

  // Decoded outputs trail a register write by one cycle
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ridx[i]) rd(ridx[i], rval[i]);
    settle();
    chk("chan reset", 1023, chans);
    chk("ring reset", 256, ring);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      g = {7'h00, c[0], c[1:0], c[1:0], c[1:0], c[1:0]};
      wr(`EMCR_IDX_GEOM, g);
      rd(`EMCR_IDX_GEOM, g);
      wr(`EMCR_IDX_SDCTL, {8'h00, c[1:0], c[1], c[0], 4'h0});
      settle();
      chk("chip kb a", 128 << c, a_kb);
      chk("chip kb b", 128 << c, b_kb);
      chk("channels", (c == 3) ? 1023 : 128 << c, chans);
      chk("ring bytes", (c == 0) ? 0 : 128 << c, ring);
      chk("bank b present", c[0], bpres);
      chk("sdram a size", c[0], sza);
      chk("sdram b size", c[1], szb);
      if (c < 3) chk("refresh spacing", 16 >> c, spacing);
    end
    $display("test geometry done");
    wr(`EMCR_IDX_GEOM, 16'h0075);
    wr(`EMCR_IDX_RXBASE, 16'h00FF);
    settle();
    chk("rx base", 21'h1FE000, rxbase);
    wr(`EMCR_IDX_GEOM, 16'h0175);
    settle();
    chk("rx base b fitted", 0, rxbase);
    $display("test rx base done");
    wr(`EMCR_IDX_PAR_DATA, 16'hC300);
    wr(`EMCR_IDX_PAR_HI, 16'h0055);
    wr(`EMCR_IDX_PAR_LO, 16'h1234);
    foreach (pa[i]) begin
      mem_addr <= pa[i];
      mem_data <= pd[i];
      @(posedge clk);
      @(posedge clk);
      chk("parity", ^(pa[i] & 23'h551234) ^ ^(pd[i] & 8'hC3), parity);
    end
    wr(`EMCR_IDX_PAR_DATA, 16'h0000);
    wr(`EMCR_IDX_PAR_HI, 16'h0000);
    wr(`EMCR_IDX_PAR_LO, 16'h0001);
    foreach (pa[i]) begin
      mem_addr <= pa[i];
      @(posedge clk);
      @(posedge clk);
      chk("parity bit 0", pa[i][0], parity);
    end
    $display("test parity done");
    wr(`EMCR_IDX_PIN_CMD, 16'h000F);
    wr(`EMCR_IDX_IDLE_ADDR, 16'h2ABC);
    wr(`EMCR_IDX_MAN_ADDR, 16'h1555);
    settle();
    chk("idle addr a", 14'h2ABC, sda_addr);
    chk("idle addr b", 14'h2ABC, sdb_addr);
    chk("idle cmd a", 3'h7, sda_cmd);
    chk("idle cmd b", 3'h7, sdb_cmd);
    na = cnt_a;
    nb = cnt_b;
    wr(`EMCR_IDX_SDCTL, 16'h0004);
    settle();
    chk("manual count a", na + 1, cnt_a);
    chk("manual addr a", 14'h1555, man_a);
    chk("manual cmd a", 3'h1, mcmd_a);
    chk("count b", nb, cnt_b);
    chk("back to idle a", 14'h2ABC, sda_addr);
    wr(`EMCR_IDX_SDCTL, 16'h0008);
    wr(`EMCR_IDX_SDCTL, 16'h0008);
    settle();
    chk("manual count b", nb + 2, cnt_b);
    chk("manual addr b", 14'h1555, man_b);
    chk("manual cmd b", 3'h1, mcmd_b);
    acc_addr <= 14'h0777;
    wr(`EMCR_IDX_SDCTL, 16'h0001);
    na = cnt_a;
    wr(`EMCR_IDX_SDCTL, 16'h0005);
    settle();
    chk("traffic addr a", 14'h0777, sda_addr);
    chk("idle addr b", 14'h2ABC, sdb_addr);
    chk("manual refused a", na, cnt_a);
    $display("test pins done");
    wr(`EMCR_IDX_REFIVL, 16'h0005);
    n = 0;
    while (rreq !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rreq !== 1'b1 && n < 50);
    chk("refresh interval", 5, n);
    $display("test refresh done");
    tally_and_finish();
  end
endmodule
